// file: bench/tb_uart_param_checksum_regs.sv
`default_nettype none
module tb_uart_param_checksum_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import upc_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    upc_apb_req_s req = '0;
    upc_apb_rsp_s rsp;
    upc_byte_s    txb = '0;
    upc_byte_s    nreq = '0;
    upc_byte_s    rxb;
    upc_cfg_s     cfg;
    upc_proto_s   pr;
    logic [3:0]   mode;
    logic         twe;
    logic [8:0]   slot = '0;
    logic [8:0]   idle = '0;
    logic [31:0]  rdata;
    logic         rerr;
    int           fails = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    logic [7:0]   ofs [8] = '{OFS_PARAM_TWO_HIGH, OFS_PARAM_TWO_LOW,
        OFS_PARAM_THREE_HIGH, OFS_PARAM_THREE_LOW, OFS_TX_CHECKSUM,
        OFS_RX_CHECKSUM, OFS_MODE, OFS_STATUS};
    logic [3:0]   cm [3] = '{MODE_LIN_CTRL, MODE_LIN_CTRL, MODE_ASYNC_8};
    logic [7:0]   cc [3] = '{8'h08, 8'h00, 8'h08};
    logic [7:0]   ce [3] = '{8'h65, 8'h10, 8'h65};
    logic [8:0]   sv [4] = '{9'h102, 9'h103, 9'h105, 9'h106};
    logic         se [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    upc_regs DUT (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .tx_byte(txb), .rx_byte(rxb), .dmx_slot(slot),
        .idle_half_bits(idle), .cfg(cfg), .proto(pr), .mode(mode),
        .tx_write_error(twe));
    upc_node node (.clk(clk), .rst(rst), .req(nreq), .rx_byte(rxb));

    initial begin
        forever #20 clk = ~clk;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // request held until pready is seen at a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task tick;
        repeat (2) @(posedge clk);
    endtask : tick

    // one byte on both the transmit path and the remote node
    task send(input logic [7:0] d, input logic p, input logic b);
        @(posedge clk);
        txb <= '{!b, p, b, d};
        nreq <= '{!b, p, b, d};
        @(posedge clk);
        txb <= '0;
        nreq <= '0;
        tick;
    endtask : send

    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            fails++;
            final_report;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk(rdata, 32'h0);
        end
        chk({31'h0, twe}, 32'h0);
        $display("test reset done");
        wr(OFS_PARAM_TWO_HIGH, 32'hFF);
        rd(OFS_PARAM_TWO_HIGH);
        chk(rdata, 32'h1);
        wr(OFS_PARAM_THREE_HIGH, 32'hFE);
        rd(OFS_PARAM_THREE_HIGH);
        chk(rdata, 32'h0);
        wr(OFS_PARAM_THREE_HIGH, 32'h01);
        wr(OFS_PARAM_TWO_LOW, 32'h103);
        wr(OFS_PARAM_THREE_LOW, 32'h05);
        rd(OFS_PARAM_TWO_LOW);
        chk(rdata, 32'h03);
        rd(8'h3C);
        chk({rdata[30:0], rerr}, 32'h1);
        wr(OFS_LINE_CONFIG, 32'hB6);
        tick;
        chk({24'h0, cfg}, 32'hB6);
        rd(OFS_LINE_CONFIG);
        chk(rdata, 32'hB6);
        chk({30'h0, rdata[POS_STOP_MODE +: 2]}, 32'h3);
        chk({31'h0, rdata[POS_RUN_OVERFLOW]}, 32'h1);
        $display("test registers done");
        wr(OFS_MODE, {28'h0, MODE_DMX});
        tick;
        chk({28'h0, mode}, {28'h0, MODE_DMX});
        chk({23'h0, pr.param_two}, 32'h103);
        chk({23'h0, pr.param_three}, 32'h105);
        foreach (sv[i]) begin
            slot <= sv[i];
            tick;
            chk({31'h0, pr.dmx_slot_keep}, {31'h0, se[i]});
        end
        wr(OFS_MODE, {28'h0, MODE_DALI});
        idle <= 9'h102;
        tick;
        chk({31'h0, pr.dali_idle_ok}, 32'h0);
        chk({31'h0, pr.dmx_slot_keep}, 32'h0);
        chk({23'h0, pr.param_three}, 32'h0);
        idle <= 9'h103;
        tick;
        chk({31'h0, pr.dali_idle_ok}, 32'h1);
        $display("test dmx dali done");
        wr(OFS_MODE, {28'h0, MODE_ADDRESS});
        wr(OFS_PARAM_TWO_LOW, 32'h3C);
        wr(OFS_PARAM_THREE_LOW, 32'hF0);
        send(8'h35, 1'b0, 1'b0);
        chk({31'h0, pr.addr_match}, 32'h1);
        send(8'h45, 1'b0, 1'b0);
        rd(OFS_STATUS);
        chk({31'h0, rdata[POS_ADDR_MATCH]}, 32'h0);
        $display("test address done");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_MODE, {28'h0, cm[i]});
            wr(OFS_LINE_CONFIG, {24'h0, cc[i]});
            wr(OFS_TX_CHECKSUM, 32'h0);
            wr(OFS_RX_CHECKSUM, 32'h0);
            send(8'h55, 1'b1, 1'b0);
            send(8'h80, 1'b0, 1'b0);
            send(8'h90, 1'b0, 1'b0);
            rd(OFS_TX_CHECKSUM);
            chk(rdata, {24'h0, ce[i]});
            rd(OFS_RX_CHECKSUM);
            chk(rdata, {24'h0, ce[i]});
        end
        $display("test checksum done");
        wr(OFS_MODE, {28'h0, MODE_LIN_RESP});
        wr(OFS_PARAM_TWO_LOW, 32'h02);
        wr(OFS_PARAM_THREE_LOW, 32'h03);
        tick;
        chk({24'h0, pr.lin_tx_count}, 32'h2);
        chk({24'h0, pr.lin_rx_count}, 32'h3);
        send(8'h00, 1'b0, 1'b1);
        send(8'h11, 1'b0, 1'b0);
        send(8'h22, 1'b0, 1'b0);
        chk({31'h0, twe}, 32'h0);
        send(8'h33, 1'b0, 1'b0);
        chk({31'h0, twe}, 32'h1);
        wr(OFS_STATUS, 32'h1);
        rd(OFS_STATUS);
        chk({31'h0, rdata[POS_TX_WRITE_ERROR]}, 32'h0);
        send(8'h00, 1'b0, 1'b1);
        send(8'h44, 1'b0, 1'b0);
        chk({31'h0, twe}, 32'h0);
        wr(OFS_PARAM_TWO_LOW, 32'h0);
        send(8'h66, 1'b0, 1'b0);
        chk({31'h0, twe}, 32'h1);
        $display("test responder done");
        wr(OFS_TX_CHECKSUM, 32'h5A);
        rst <= 1'b1;
        tick;
        rst <= 1'b0;
        rd(OFS_TX_CHECKSUM);
        chk(rdata, {24'h0, RST_BYTE});
        rd(OFS_PARAM_THREE_LOW);
        chk(rdata, {24'h0, RST_BYTE});
        chk({28'h0, mode}, {28'h0, RST_MODE});
        chk({31'h0, twe}, 32'h0);
        $display("test mid reset done");
        final_report;
    end
endmodule : tb_uart_param_checksum_regs
`default_nettype wire

// file: bench/upc_node.sv
`default_nettype none
// remote node: hands each byte to the receive path one cycle later,
// valid only for that one cycle
module upc_node (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire upc_pkg::upc_byte_s req,
    output var  upc_pkg::upc_byte_s rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    import upc_pkg::*;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_byte <= '0;
        end else begin
            rx_byte <= req;
        end
    end
endmodule : upc_node
`default_nettype wire

// file: verilog/upc_pkg.sv
`default_nettype none
package upc_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_PARAM_ONE_HIGH   = 8'h00;
    localparam logic [7:0] OFS_PARAM_ONE_LOW    = 8'h04;
    localparam logic [7:0] OFS_PARAM_TWO_HIGH   = 8'h08;
    localparam logic [7:0] OFS_PARAM_TWO_LOW    = 8'h0C;
    localparam logic [7:0] OFS_PARAM_THREE_HIGH = 8'h10;
    localparam logic [7:0] OFS_PARAM_THREE_LOW  = 8'h14;
    localparam logic [7:0] OFS_TX_CHECKSUM      = 8'h18;
    localparam logic [7:0] OFS_RX_CHECKSUM      = 8'h1C;
    localparam logic [7:0] OFS_LINE_CONFIG      = 8'h20;
    localparam logic [7:0] OFS_MODE             = 8'h24;
    localparam logic [7:0] OFS_STATUS           = 8'h28;

    // line_config_control field positions
    localparam int POS_FLOW_CONTROL      = 0;
    localparam int POS_TRANSMIT_POLARITY = 2;
    localparam int POS_CHECKSUM_ENABLE   = 3;
    localparam int POS_STOP_MODE         = 4;
    localparam int POS_RECEIVE_POLARITY  = 6;
    localparam int POS_RUN_OVERFLOW      = 7;
    // status register field positions
    localparam int POS_TX_WRITE_ERROR    = 0;
    localparam int POS_ADDR_MATCH        = 1;

    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [8:0] RST_PARAM      = 9'h000;
    localparam logic [3:0] RST_MODE       = 4'h0;

    // operating mode codes
    localparam logic [3:0] MODE_ASYNC_8   = 4'h0;
    localparam logic [3:0] MODE_ADDRESS   = 4'h4;
    localparam logic [3:0] MODE_DALI      = 4'h8;
    localparam logic [3:0] MODE_LIN_RESP  = 4'hB;
    localparam logic [3:0] MODE_LIN_CTRL  = 4'hC;
    localparam logic [3:0] MODE_DMX       = 4'hA;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } upc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } upc_apb_rsp_s;

    // byte event from the transmit or receive path
    typedef struct packed {
        logic       valid;
        logic       is_pid;
        logic       is_break;
        logic [7:0] data;
    } upc_byte_s;

    typedef struct packed {
        logic       run_overflow;
        logic       receive_polarity;
        logic [1:0] stop_mode;
        logic       checksum_enable;
        logic       transmit_polarity;
        logic [1:0] flow_control;
    } upc_cfg_s;

    typedef struct packed {
        logic [8:0] param_two;
        logic [8:0] param_three;
        logic       dmx_slot_keep;
        logic       dali_idle_ok;
        logic [7:0] lin_tx_count;
        logic [7:0] lin_rx_count;
        logic       addr_match;
    } upc_proto_s;
endpackage : upc_pkg
`default_nettype wire

// file: verilog/upc_regs.sv
// Function
// - param two is 9 bits; bit 8 at high byte bit 0, rest reads zero
// - param three is 9 bits; bit 8 at high byte bit 0
// - DMX mode: param two is first kept slot address
// - DMX mode: param three is last kept slot address
// - DALI mode: param two is idle threshold in half-bit periods
// - LIN responder: param two low byte counts bytes to transmit
// - LIN responder: param three low byte counts bytes to receive
// - address mode: match when (addr xor p2 low) and p3 low is zero
// - LIN with checksum enable: tx sum includes protected identifier
// - LIN without checksum enable: tx sum excludes protected identifier
// - other modes, enable set: sum tx bytes since clear; else unused
// - receive checksum computed the same way over received bytes
// - line config: run overflow, rx pol, stop mode, csum en, tx pol, flow
// - checksums and parameter bytes read/write, reset to zero
// - LIN responder: tx write error if p2 zero or too many writes
`default_nettype none
module upc_regs (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire upc_pkg::upc_apb_req_s apb_req,
    output      upc_pkg::upc_apb_rsp_s apb_rsp,
    input  wire upc_pkg::upc_byte_s    tx_byte,
    input  wire upc_pkg::upc_byte_s    rx_byte,
    input  wire logic [8:0]            dmx_slot,
    input  wire logic [8:0]            idle_half_bits,
    output      upc_pkg::upc_cfg_s     cfg,
    output      upc_pkg::upc_proto_s   proto,
    output      logic [3:0]            mode,
    output      logic                  tx_write_error
);
    import upc_pkg::*;

    typedef struct packed {
        upc_apb_rsp_s rsp;
        logic [8:0]   param_one;
        logic [8:0]   param_two;
        logic [8:0]   param_three;
        logic [7:0]   tx_checksum;
        logic [7:0]   rx_checksum;
        upc_cfg_s     cfg;
        logic [3:0]   mode;
        logic         tx_write_error;
        logic [7:0]   tx_written;
        upc_proto_s   proto;
    } upc_state_s;

    upc_state_s st;
    upc_state_s next_st;

    logic       wr_en;
    logic       rd_en;
    logic       is_lin;
    logic [7:0] wbyte;
    logic [7:0] rdata;
    logic       mapped;

    assign apb_rsp        = st.rsp;
    assign cfg            = st.cfg;
    assign proto          = st.proto;
    assign mode           = st.mode;
    assign tx_write_error = st.tx_write_error;

    assign wr_en  = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & ~st.rsp.pready;
    assign rd_en  = apb_req.psel & apb_req.penable & ~apb_req.pwrite
                  & ~st.rsp.pready;
    assign wbyte  = apb_req.pwdata[7:0];
    assign is_lin = (st.mode == MODE_LIN_RESP) | (st.mode == MODE_LIN_CTRL);

    // read mux
    always_comb begin
        mapped = 1'b1;
        rdata  = 8'h00;
        unique case (apb_req.paddr)
            OFS_PARAM_ONE_HIGH:   rdata = {7'h00, st.param_one[8]};
            OFS_PARAM_ONE_LOW:    rdata = st.param_one[7:0];
            OFS_PARAM_TWO_HIGH:   rdata = {7'h00, st.param_two[8]};
            OFS_PARAM_TWO_LOW:    rdata = st.param_two[7:0];
            OFS_PARAM_THREE_HIGH: rdata = {7'h00, st.param_three[8]};
            OFS_PARAM_THREE_LOW:  rdata = st.param_three[7:0];
            OFS_TX_CHECKSUM:      rdata = st.tx_checksum;
            OFS_RX_CHECKSUM:      rdata = st.rx_checksum;
            OFS_LINE_CONFIG:      rdata = st.cfg;
            OFS_MODE:             rdata = {4'h0, st.mode};
            OFS_STATUS:           rdata = {6'h00, st.proto.addr_match,
                                           st.tx_write_error};
            default:              mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.rsp.pready  = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        next_st.rsp.prdata  = 32'h0000_0000;
        if (wr_en | rd_en) begin
            next_st.rsp.pready  = 1'b1;
            next_st.rsp.pslverr = ~mapped;
            next_st.rsp.prdata  = {24'h000000, rdata};
        end

        // checksum accumulation, modulo 256
        if (tx_byte.valid) begin
            // include PID only per enable in LIN
            if (is_lin ? (st.cfg.checksum_enable | ~tx_byte.is_pid)
                       : st.cfg.checksum_enable) begin
                next_st.tx_checksum = st.tx_checksum + tx_byte.data;
            end
        end
        if (rx_byte.valid) begin
            if (is_lin ? (st.cfg.checksum_enable | ~rx_byte.is_pid)
                       : st.cfg.checksum_enable) begin
                next_st.rx_checksum = st.rx_checksum + rx_byte.data;
            end
        end

        // responder byte count restarts at break
        if (tx_byte.is_break) begin
            next_st.tx_written = 8'h00;
        end

        if (wr_en) begin
            unique case (apb_req.paddr)
                OFS_PARAM_ONE_HIGH:   next_st.param_one[8]   = wbyte[0];
                OFS_PARAM_ONE_LOW:    next_st.param_one[7:0] = wbyte;
                OFS_PARAM_TWO_HIGH:   next_st.param_two[8]   = wbyte[0];
                OFS_PARAM_TWO_LOW:    next_st.param_two[7:0] = wbyte;
                OFS_PARAM_THREE_HIGH: next_st.param_three[8] = wbyte[0];
                OFS_PARAM_THREE_LOW:  next_st.param_three[7:0] = wbyte;
                OFS_TX_CHECKSUM:      next_st.tx_checksum = wbyte;
                OFS_RX_CHECKSUM:      next_st.rx_checksum = wbyte;
                OFS_LINE_CONFIG:      next_st.cfg = wbyte;
                OFS_MODE:             next_st.mode = wbyte[3:0];
                // write one to clear the error flag
                OFS_STATUS: begin
                    if (wbyte[POS_TX_WRITE_ERROR]) begin
                        next_st.tx_write_error = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // error set wins over the clear
        if (tx_byte.valid & ~tx_byte.is_pid
            & (st.mode == MODE_LIN_RESP)) begin
            if ((st.param_two[7:0] == 8'h00)
                || (st.tx_written >= st.param_two[7:0])) begin
                next_st.tx_write_error = 1'b1;
            end
            if (st.tx_written != 8'hFF) begin
                next_st.tx_written = st.tx_written + 8'h01;
            end
        end

        // protocol outputs zero outside their modes
        next_st.proto = '0;
        if ((st.mode == MODE_DMX) || (st.mode == MODE_DALI)) begin
            next_st.proto.param_two = st.param_two;
        end
        if (st.mode == MODE_DMX) begin
            next_st.proto.param_three = st.param_three;
            next_st.proto.dmx_slot_keep = (dmx_slot >= st.param_two)
                                        && (dmx_slot <= st.param_three);
        end
        if (st.mode == MODE_DALI) begin
            next_st.proto.dali_idle_ok = (idle_half_bits >= st.param_two);
        end
        if (st.mode == MODE_LIN_RESP) begin
            next_st.proto.lin_tx_count = st.param_two[7:0];
            next_st.proto.lin_rx_count = st.param_three[7:0];
        end
        if ((st.mode == MODE_ADDRESS) && rx_byte.valid) begin
            next_st.proto.addr_match = (((rx_byte.data
                ^ st.param_two[7:0]) & st.param_three[7:0]) == 8'h00);
        end else if (st.mode == MODE_ADDRESS) begin
            next_st.proto.addr_match = st.proto.addr_match;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    addr_match_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_ADDRESS && rx_byte.valid
         && (((rx_byte.data ^ st.param_two[7:0]) & st.param_three[7:0])
             == 8'h00)) |=> proto.addr_match)
        else $error("address match missed");

    lin_tx_sum_a: assert property (
        @(posedge clk) disable iff (rst)
        (is_lin && st.cfg.checksum_enable && tx_byte.valid && !wr_en)
        |=> st.tx_checksum == $past(st.tx_checksum) + $past(tx_byte.data))
        else $error("tx checksum not accumulated");

    lin_pid_skip_a: assert property (
        @(posedge clk) disable iff (rst)
        (is_lin && !st.cfg.checksum_enable && tx_byte.valid
         && tx_byte.is_pid && !wr_en) |=> $stable(st.tx_checksum))
        else $error("pid summed while excluded");

    tx_sum_off_a: assert property (
        @(posedge clk) disable iff (rst)
        (!is_lin && !st.cfg.checksum_enable && !wr_en)
        |=> $stable(st.tx_checksum))
        else $error("tx checksum moved while disabled");

    rx_sum_a: assert property (
        @(posedge clk) disable iff (rst)
        (!is_lin && st.cfg.checksum_enable && rx_byte.valid && !wr_en)
        |=> st.rx_checksum == $past(st.rx_checksum) + $past(rx_byte.data))
        else $error("rx checksum not accumulated");

    tx_wr_err_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_LIN_RESP && tx_byte.valid && !tx_byte.is_pid
         && st.param_two[7:0] == 8'h00) |=> tx_write_error)
        else $error("write error not flagged");

    lin_counts_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_LIN_RESP) ##1 (st.mode == MODE_LIN_RESP)
        |-> proto.lin_tx_count == $past(st.param_two[7:0]))
        else $error("lin tx count wrong");

    unused_param_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_ASYNC_8) |=> (proto.param_two == 9'h000
         && proto.lin_tx_count == 8'h00))
        else $error("unused parameter leaked");

    // APB answer one cycle after access
    apb_answer_a: assert property (
        @(posedge clk) disable iff (rst)
        (apb_req.psel && apb_req.penable && !apb_rsp.pready)
        |=> apb_rsp.pready)
        else $error("apb answer late");

    p2_high_read_a: assert property (
        @(posedge clk) disable iff (rst)
        (rd_en && apb_req.paddr == OFS_PARAM_TWO_HIGH)
        |=> apb_rsp.prdata == {31'h0, $past(st.param_two[8])})
        else $error("param two high byte wrong");

    p3_high_read_a: assert property (
        @(posedge clk) disable iff (rst)
        (rd_en && apb_req.paddr == OFS_PARAM_THREE_HIGH)
        |=> apb_rsp.prdata == {31'h0, $past(st.param_three[8])})
        else $error("param three high byte wrong");

    dmx_first_slot_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_DMX && dmx_slot < st.param_two)
        |=> !proto.dmx_slot_keep)
        else $error("slot before block kept");

    dmx_last_slot_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_DMX && dmx_slot > st.param_three)
        |=> !proto.dmx_slot_keep)
        else $error("slot after block kept");

    dali_idle_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_DALI && idle_half_bits >= st.param_two)
        |=> proto.dali_idle_ok)
        else $error("idle threshold missed");

    lin_rx_count_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_LIN_RESP) ##1 (st.mode == MODE_LIN_RESP)
        |-> proto.lin_rx_count == $past(st.param_three[7:0]))
        else $error("lin rx count wrong");

    addr_miss_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_ADDRESS && rx_byte.valid && (((rx_byte.data
         ^ st.param_two[7:0]) & st.param_three[7:0]) != 8'h00))
        |=> !proto.addr_match)
        else $error("address mismatch accepted");

    lin_rx_sum_a: assert property (
        @(posedge clk) disable iff (rst)
        (is_lin && st.cfg.checksum_enable && rx_byte.valid && !wr_en)
        |=> st.rx_checksum == $past(st.rx_checksum) + $past(rx_byte.data))
        else $error("lin rx checksum not accumulated");

    rx_pid_skip_a: assert property (
        @(posedge clk) disable iff (rst)
        (is_lin && !st.cfg.checksum_enable && rx_byte.valid
         && rx_byte.is_pid && !wr_en) |=> $stable(st.rx_checksum))
        else $error("rx pid summed while excluded");

    cfg_fields_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_LINE_CONFIG)
        |=> (cfg.stop_mode == $past(apb_req.pwdata[POS_STOP_MODE +: 2])
             && cfg.checksum_enable
                == $past(apb_req.pwdata[POS_CHECKSUM_ENABLE])))
        else $error("config field misplaced");

    reset_zero_a: assert property (
        @(posedge clk) $fell(rst) |-> (st.param_two == RST_PARAM
         && st.param_three == RST_PARAM && st.tx_checksum == RST_BYTE
         && st.rx_checksum == RST_BYTE && st.mode == RST_MODE))
        else $error("register not cleared by reset");

    tx_sum_load_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_TX_CHECKSUM)
        |=> st.tx_checksum == $past(apb_req.pwdata[7:0]))
        else $error("tx checksum write lost");

    rx_sum_load_a: assert property (
        @(posedge clk) disable iff (rst)
        (wr_en && apb_req.paddr == OFS_RX_CHECKSUM)
        |=> st.rx_checksum == $past(apb_req.pwdata[7:0]))
        else $error("rx checksum write lost");

    tx_over_count_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_LIN_RESP && tx_byte.valid && !tx_byte.is_pid
         && st.tx_written >= st.param_two[7:0]) |=> tx_write_error)
        else $error("excess write not flagged");

    tx_err_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (tx_write_error && !(wr_en && apb_req.paddr == OFS_STATUS
         && apb_req.pwdata[POS_TX_WRITE_ERROR])) |=> tx_write_error)
        else $error("write error dropped");

    dali_unused_a: assert property (
        @(posedge clk) disable iff (rst)
        (st.mode == MODE_DALI) |=> (proto.param_three == 9'h000
         && !proto.dmx_slot_keep && proto.lin_rx_count == 8'h00))
        else $error("unused parameter leaked in dali");
endmodule : upc_regs
`default_nettype wire
